/* File: inc/fpc_pkg.sv */
// Package for the program-memory controller register front end
package fpc_pkg;

  // Register byte offsets within the peripheral window
  localparam logic [15:0] OFS_CONTROL  = 16'hE400;
  localparam logic [15:0] OFS_KEY      = 16'hF410;
  localparam logic [15:0] OFS_TARGET   = 16'hE420;
  localparam logic [15:0] OFS_DATA     = 16'hF430;
  localparam logic [15:0] OFS_SOURCE   = 16'hF440;

  // Alias offsets added to a base register
  localparam logic [15:0] ALIAS_CLR    = 16'h0004;
  localparam logic [15:0] ALIAS_SET    = 16'h0008;
  localparam logic [15:0] ALIAS_INV    = 16'h000C;

  // Control word field positions
  localparam int          BIT_START    = 15;
  localparam int          BIT_PERMIT   = 14;
  localparam int          BIT_WFAULT   = 13;
  localparam int          BIT_LVFAULT  = 12;
  localparam int          BIT_LVSTATE  = 11;
  localparam int          OPSEL_LO     = 0;
  localparam int          OPSEL_W      = 4;

  // Implemented bits of the control word; others read zero
  localparam logic [31:0] CONTROL_MASK = 32'h0000F80F;

  // Common reset value of every register
  localparam logic [31:0] RESET_VALUE  = 32'h00000000;

  // Memory geometry in bytes and instruction words
  localparam int          PAGE_BYTES   = 1024;
  localparam int          ROW_BYTES    = 128;
  localparam int          WORD_BYTES   = 4;
  localparam int          PAGE_WORDS   = PAGE_BYTES / WORD_BYTES;
  localparam int          ROW_WORDS    = ROW_BYTES / WORD_BYTES;

  // Alias kinds of a write
  typedef enum logic [1:0] {
    WR_PLAIN,
    WR_CLR,
    WR_SET,
    WR_INV
  } fpc_wmode_e;

  // Decoded operation outputs
  typedef struct packed {
    logic [31:0] page_base;
    logic [31:0] row_base;
    logic [3:0]  op_select;
    logic        permit;
  } fpc_op_s;

endpackage : fpc_pkg

/* File: rtl/fpc_regs.sv */
// Register front end of the program-memory write controller
//
// Notes on behaviour
// - Page is 1 KB, 256 instruction words
// - Row is 128 bytes, 32 words, aligned to 128 bytes
// - Control and target have clear/set/invert aliases
// - Unimplemented bits read zero, ignore writes
// - All registers reset to zero
// - Accept requests from software anywhere
// - Serial programming path writes memory faster
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module fpc_regs #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST,
  // Classic Wishbone slave
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [ADDR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  output logic                    WB_ERR_O,
  // Status inputs from the memory array
  input  wire logic               LOW_VOLTAGE_STATE_IN,
  input  wire logic               WRITE_FAULT_EVENT,
  input  wire logic               LOW_VOLTAGE_FAULT_EVENT,
  input  wire logic               OP_DONE,
  // Serial programming path
  input  wire logic               SERIAL_PROG_ACTIVE,
  input  wire logic [31:0]        SERIAL_PROG_ADDR,
  input  wire logic [31:0]        SERIAL_PROG_DATA,
  // Outputs to the memory array
  output logic                    OP_START,
  output logic      [3:0]         OP_SELECT,
  output logic                    WRITE_PERMIT,
  output logic      [31:0]        TARGET_ADDRESS,
  output logic      [31:0]        PAGE_BASE,
  output logic      [31:0]        ROW_BASE,
  output logic      [31:0]        PROGRAM_DATA,
  output logic      [31:0]        ROW_SOURCE,
  output logic      [31:0]        UNLOCK_KEY
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Small pure helpers; lane masks widen the four byte selects

  // Merge a bus write into a register by alias kind and byte lanes
  // Plain writes honour lanes; aliases act on bits written one in enabled lanes
  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel,
                                        input fpc_pkg::fpc_wmode_e mode);
    logic [31:0] lane;
    logic [31:0] r;
    lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    r    = cur;
    case (mode)
      fpc_pkg::WR_PLAIN: r = (cur & ~lane) | (wd & lane);
      fpc_pkg::WR_CLR:   r = cur & ~(wd & lane);
      fpc_pkg::WR_SET:   r = cur | (wd & lane);
      fpc_pkg::WR_INV:   r = cur ^ (wd & lane);
      default:           r = cur;
    endcase
    return r;
  endfunction : merge

  // Alias kind from offset relative to a base register
  function automatic fpc_pkg::fpc_wmode_e alias_kind(input logic [15:0] rel);
    fpc_pkg::fpc_wmode_e k;
    k = fpc_pkg::WR_PLAIN;
    case (rel)
      fpc_pkg::ALIAS_CLR: k = fpc_pkg::WR_CLR;
      fpc_pkg::ALIAS_SET: k = fpc_pkg::WR_SET;
      fpc_pkg::ALIAS_INV: k = fpc_pkg::WR_INV;
      default:            k = fpc_pkg::WR_PLAIN;
    endcase
    return k;
  endfunction : alias_kind

  // Hardware flag that stays set until software clears it
  function automatic logic sticky(input logic cur, input logic ev);
    return cur | ev;
  endfunction : sticky

  // Base of the aligned unit of a given size that holds an address
  function automatic logic [31:0] unit_base(input logic [31:0] a, input int unit_bytes);
    return a & ~32'(unit_bytes - 1);
  endfunction : unit_base

  // Contents seen by a read at the decoded address; holes read zero
  function automatic logic [31:0] read_word(input logic [4:0]  hits,
                                            input logic [31:0] ctl,
                                            input logic [31:0] tgt,
                                            input logic [31:0] kv,
                                            input logic [31:0] dv,
                                            input logic [31:0] sv);
    logic [31:0] v;
    v = 32'h00000000;
    if (hits[0]) v = ctl & fpc_pkg::CONTROL_MASK;
    if (hits[1]) v = tgt;
    if (hits[2]) v = kv;
    if (hits[3]) v = dv;
    if (hits[4]) v = sv;
    return v;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Only the low 16 bits of the window are decoded; the upper bits
  // are left to the interconnect. Aliases read back the base word.

  // Decode results, valid in the request cycle
  logic [15:0] adr16;
  logic        hit_ctl;
  logic        hit_tgt;
  logic        hit_key;
  logic        hit_dat;
  logic        hit_src;
  logic        hit_any;
  logic        req;
  fpc_pkg::fpc_wmode_e ctl_mode;
  fpc_pkg::fpc_wmode_e tgt_mode;

  // Base plus three aliases for control and target
  always_comb begin
    adr16    = 16'(WB_ADR_I);
    hit_ctl  = (adr16[15:4] == fpc_pkg::OFS_CONTROL[15:4]) && (adr16[1:0] == 2'h0);
    hit_tgt  = (adr16[15:4] == fpc_pkg::OFS_TARGET[15:4]) && (adr16[1:0] == 2'h0);
    hit_key  = (adr16 == fpc_pkg::OFS_KEY);
    hit_dat  = (adr16 == fpc_pkg::OFS_DATA);
    hit_src  = (adr16 == fpc_pkg::OFS_SOURCE);
    hit_any  = hit_ctl | hit_tgt | hit_key | hit_dat | hit_src;
    ctl_mode = alias_kind(adr16 - fpc_pkg::OFS_CONTROL);
    tgt_mode = alias_kind(adr16 - fpc_pkg::OFS_TARGET);
    req      = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  // Two groups: the control word with its hardware flags, and the
  // address and data words loaded by software or the serial path.
  // Event inputs are synchronous to CLK; a held level keeps a flag set.

  logic [31:0] control_q, control_d;
  logic [31:0] key_q,     key_d;
  logic [31:0] target_q,  target_d;
  logic [31:0] data_q,    data_d;
  logic [31:0] source_q,  source_d;
  logic        start_q,   start_d;
  logic        start_bit;

  // Control word; software first, hardware events then override it
  always_comb begin
    control_d = control_q;
    if (req && WB_WE_I && hit_ctl) begin
      control_d = merge(control_q, WB_DAT_I, WB_SEL_I, ctl_mode);
    end
    // Completion wins over a software set of start in the same cycle
    if (OP_DONE) begin
      control_d[fpc_pkg::BIT_START] = 1'b0;
    end
    // Fault sets win over a software clear, so no fault is ever lost
    control_d[fpc_pkg::BIT_WFAULT]  = sticky(control_d[fpc_pkg::BIT_WFAULT],
                                             WRITE_FAULT_EVENT);
    control_d[fpc_pkg::BIT_LVFAULT] = sticky(control_d[fpc_pkg::BIT_LVFAULT],
                                             LOW_VOLTAGE_FAULT_EVENT);
    // State bit is read-only and simply follows its input
    control_d[fpc_pkg::BIT_LVSTATE] = LOW_VOLTAGE_STATE_IN;
    control_d = control_d & fpc_pkg::CONTROL_MASK;
    // Start pulse on a rising start bit, or a serial word
    start_bit = control_d[fpc_pkg::BIT_START] & ~control_q[fpc_pkg::BIT_START];
    start_d   = start_bit | SERIAL_PROG_ACTIVE;
  end

  // Control registers; all clear to zero on reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      control_q <= fpc_pkg::RESET_VALUE;
      start_q   <= 1'b0;
    end else begin
      control_q <= control_d;
      start_q   <= start_d;
    end
  end

  // Key, target, data and source; software writes with byte lanes
  always_comb begin
    key_d    = key_q;
    target_d = target_q;
    data_d   = data_q;
    source_d = source_q;
    if (req && WB_WE_I) begin
      if (hit_tgt) target_d = merge(target_q, WB_DAT_I, WB_SEL_I, tgt_mode);
      if (hit_key) key_d    = merge(key_q, WB_DAT_I, WB_SEL_I, fpc_pkg::WR_PLAIN);
      if (hit_dat) data_d   = merge(data_q, WB_DAT_I, WB_SEL_I, fpc_pkg::WR_PLAIN);
      if (hit_src) source_d = merge(source_q, WB_DAT_I, WB_SEL_I, fpc_pkg::WR_PLAIN);
    end
    // Serial path overrides software; it streams words faster
    if (SERIAL_PROG_ACTIVE) begin
      target_d = SERIAL_PROG_ADDR;
      data_d   = SERIAL_PROG_DATA;
    end
  end

  // Address and data registers; all clear to zero on reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      key_q    <= fpc_pkg::RESET_VALUE;
      target_q <= fpc_pkg::RESET_VALUE;
      data_q   <= fpc_pkg::RESET_VALUE;
      source_q <= fpc_pkg::RESET_VALUE;
    end else begin
      key_q    <= key_d;
      target_q <= target_d;
      data_q   <= data_d;
      source_q <= source_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Geometry decode of the target
  // Bases come from the next target so they move on the same edge
  // as the target itself; the array never sees a stale pair.

  // Registered geometry and operation fields
  fpc_pkg::fpc_op_s op_d, op_q;

  // Page and row bases drop the low offset bits
  always_comb begin
    op_d.page_base = unit_base(target_d, fpc_pkg::PAGE_BYTES);
    op_d.row_base  = unit_base(target_d, fpc_pkg::ROW_BYTES);
    op_d.op_select = control_d[fpc_pkg::OPSEL_LO +: fpc_pkg::OPSEL_W];
    op_d.permit    = control_d[fpc_pkg::BIT_PERMIT];
  end

  // Registered so the outputs come from flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      op_q <= '0;
    end else begin
      op_q <= op_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer
  // A request is taken with CYC and STB high and no answer pending;
  // writes land at that edge. ACK or ERR then stands one cycle, and a
  // strobe still held after it is taken again, so masters must drop it.
  // The error strobe keeps software from hanging on a hole in the map.

  // Answer state; read data holds until the next read
  logic [31:0] rdat_d, rdat_q;
  logic        ack_d,  ack_q;
  logic        err_d,  err_q;

  // One-cycle answer; unmapped addresses take the error strobe
  always_comb begin
    rdat_d = rdat_q;
    ack_d  = req & hit_any;
    err_d  = req & ~hit_any;
    if (req && !WB_WE_I) begin
      rdat_d = read_word({hit_src, hit_dat, hit_key, hit_tgt, hit_ctl}, control_q, target_q,
                         key_q, data_q, source_q);
    end
  end

  // Answer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdat_q <= 32'h00000000;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      rdat_q <= rdat_d;
      ack_q  <= ack_d;
      err_q  <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs straight from flops
  // No logic after the registers, so output timing is clock to out only
  assign WB_DAT_O       = rdat_q;
  assign WB_ACK_O       = ack_q;
  assign WB_ERR_O       = err_q;
  assign OP_START       = start_q;
  assign OP_SELECT      = op_q.op_select;
  assign WRITE_PERMIT   = op_q.permit;
  assign TARGET_ADDRESS = target_q;
  assign PAGE_BASE      = op_q.page_base;
  assign ROW_BASE       = op_q.row_base;
  assign PROGRAM_DATA   = data_q;
  assign ROW_SOURCE     = source_q;
  assign UNLOCK_KEY     = key_q;

endmodule : fpc_regs

/* File: sim/fpc_regs_asserts.sv */
// Checker for the program-memory controller register front end
`timescale 1ns/10ps
module fpc_regs_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  // Serial path and outputs
  input wire logic        SERIAL_PROG_ACTIVE,
  input wire logic [31:0] SERIAL_PROG_ADDR,
  input wire logic        OP_START,
  input wire logic [31:0] TARGET_ADDRESS,
  input wire logic [31:0] PAGE_BASE,
  input wire logic [31:0] ROW_BASE,
  input wire logic [31:0] UNLOCK_KEY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Answer lasts one cycle, so a held strobe is not answered twice in a row
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_req_answered: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
    |=> WB_ACK_O || WB_ERR_O) else $error("request not answered");
  a_no_spurious: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O && !WB_ERR_O)
    else $error("answer without request");
  a_page_align: assert property (PAGE_BASE == (TARGET_ADDRESS & 32'hFFFFFC00))
    else $error("page base wrong");
  a_row_align: assert property (ROW_BASE == (TARGET_ADDRESS & 32'hFFFFFF80))
    else $error("row base wrong");
  a_serial_load: assert property (SERIAL_PROG_ACTIVE
    |=> TARGET_ADDRESS == $past(SERIAL_PROG_ADDR)) else $error("serial load missed");
  a_serial_start: assert property (SERIAL_PROG_ACTIVE |-> ##[1:2] OP_START)
    else $error("serial start missed");
  a_key_held: assert property (!(WB_CYC_I && WB_STB_I && WB_WE_I) |=> $stable(UNLOCK_KEY))
    else $error("key changed without write");
  // Main scenarios
  c_write: cover property (WB_ACK_O && WB_WE_I);
  c_refused: cover property (WB_ERR_O);
  c_serial: cover property (SERIAL_PROG_ACTIVE ##1 OP_START);
endmodule : fpc_regs_asserts
bind fpc_regs fpc_regs_asserts u_chk (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .SERIAL_PROG_ACTIVE(SERIAL_PROG_ACTIVE), .SERIAL_PROG_ADDR(SERIAL_PROG_ADDR),
  .OP_START(OP_START), .TARGET_ADDRESS(TARGET_ADDRESS), .PAGE_BASE(PAGE_BASE),
  .ROW_BASE(ROW_BASE), .UNLOCK_KEY(UNLOCK_KEY));

/* File: sim/tb.sv */
// Self-checking testbench for the program-memory controller register front end
`timescale 1ns/10ps
module tb;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sp = 0;
  logic        lvs = 0, wf = 0, lvf = 0, done = 0, ack, err, ops, perm, e, pl, st_rise;
  logic [15:0] adr = '0;
  logic [3:0]  sel = '0, opsel;
  logic [31:0] wdat = '0, spa = '0, spd = '0, rd, r, m_key, m_tgt, m_ctl;
  logic [31:0] dat_o, tgt, pgb, rwb, pdat, rsrc, key;
  int          miscompares = 0, cmp_count = 0;
  // Writable control bits; the low-voltage state bit only follows its input
  localparam logic [31:0] WMASK = fpc_pkg::CONTROL_MASK & 32'hFFFFF7FF;
  localparam logic [15:0] OFS[5] = '{fpc_pkg::OFS_CONTROL, fpc_pkg::OFS_KEY,
    fpc_pkg::OFS_TARGET, fpc_pkg::OFS_DATA, fpc_pkg::OFS_SOURCE};
  always #5 clk = ~clk;
  fpc_regs u_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .WB_ERR_O(err), .LOW_VOLTAGE_STATE_IN(lvs), .WRITE_FAULT_EVENT(wf),
    .LOW_VOLTAGE_FAULT_EVENT(lvf), .OP_DONE(done), .SERIAL_PROG_ACTIVE(sp),
    .SERIAL_PROG_ADDR(spa), .SERIAL_PROG_DATA(spd), .OP_START(ops), .OP_SELECT(opsel),
    .WRITE_PERMIT(perm), .TARGET_ADDRESS(tgt), .PAGE_BASE(pgb), .ROW_BASE(rwb),
    .PROGRAM_DATA(pdat), .ROW_SOURCE(rsrc), .UNLOCK_KEY(key));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; waits for the answer, read data taken at the ack edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
    rd = dat_o;
    e = err;
    pl = ops;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0, 4'hF);
    chk(rd, exp);
  endtask : rdchk
  // Clear, set and invert act only on bits written as one
  function automatic logic [31:0] apl(input logic [31:0] o, d, input int k);
    case (k)
      0: return d;
      1: return o & ~d;
      2: return o | d;
      default: return o ^ d;
    endcase
  endfunction : apl
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // Watchdog far beyond the roughly 130 cycles the tests need
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(86));
    repeat (5) @(posedge clk);
    rst <= 0;
    foreach (OFS[i]) rdchk(OFS[i], 32'h0);
    $display("reset values done");
    for (int i = 1; i < 5; i++) begin
      r = $urandom;
      wb(1, OFS[i], r, 4'hF);
      rdchk(OFS[i], r);
      chk(i == 1 ? key : i == 2 ? tgt : i == 3 ? pdat : rsrc, r);
    end
    // Two low lanes only; upper half must survive
    wb(0, fpc_pkg::OFS_KEY, 32'h0, 4'hF);
    m_key = rd;
    r = $urandom;
    wb(1, fpc_pkg::OFS_KEY, r, 4'h3);
    m_key = {m_key[31:16], r[15:0]};
    rdchk(fpc_pkg::OFS_KEY, m_key);
    chk(key, m_key);
    $display("plain access done");
    wb(0, fpc_pkg::OFS_TARGET, 32'h0, 4'hF);
    m_tgt = rd;
    m_ctl = 32'h0;
    lvs <= 1'($urandom);
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      wb(1, fpc_pkg::OFS_TARGET + 16'(4 * k), r, 4'hF);
      m_tgt = apl(m_tgt, r, k);
      rdchk(fpc_pkg::OFS_TARGET, m_tgt);
      chk(pgb, m_tgt & 32'hFFFFFC00);
      chk(rwb, m_tgt & 32'hFFFFFF80);
      r = $urandom;
      wb(1, fpc_pkg::OFS_CONTROL + 16'(4 * k), r, 4'hF);
      st_rise = ~m_ctl[15];
      m_ctl = apl(m_ctl, r, k) & WMASK;
      chk({31'h0, pl}, {31'h0, st_rise & m_ctl[15]});
      rdchk(fpc_pkg::OFS_CONTROL, m_ctl | {20'h0, lvs, 11'h0});
      chk({28'h0, opsel}, {28'h0, m_ctl[3:0]});
      chk({31'h0, perm}, {31'h0, m_ctl[14]});
    end
    // Fault flags are sticky, done drops start
    @(posedge clk);
    wf <= 1;
    lvf <= 1;
    done <= 1;
    @(posedge clk);
    wf <= 0;
    lvf <= 0;
    done <= 0;
    m_ctl = (m_ctl | 32'h00003000) & 32'hFFFF7FFF;
    rdchk(fpc_pkg::OFS_CONTROL + fpc_pkg::ALIAS_SET, m_ctl | {20'h0, lvs, 11'h0});
    $display("alias access done");
    wb(1, 16'h1000, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, e}, 32'h1);
    rdchk(fpc_pkg::OFS_KEY, m_key);
    $display("unmapped access done");
    @(posedge clk);
    sp <= 1;
    spa <= $urandom;
    spd <= $urandom;
    @(posedge clk);
    sp <= 0;
    rdchk(fpc_pkg::OFS_TARGET, spa);
    rdchk(fpc_pkg::OFS_DATA, spd);
    chk(pdat, spd);
    chk(tgt, spa);
    $display("serial path done");
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rdchk(fpc_pkg::OFS_TARGET, 32'h0);
    rdchk(fpc_pkg::OFS_KEY, 32'h0);
    chk(pdat, 32'h0);
    chk(rsrc, 32'h0);
    $display("second reset done");
    summarize();
  end
endmodule : tb
